/* verilog/mstd_regs.svh */
`ifndef MSTD_REGS_SVH
`define MSTD_REGS_SVH
// ==========================================================================
// per-channel register block, byte offsets within the channel's window
`define MSTD_OFF_CFG 5'h00
`define MSTD_OFF_RSTART 5'h04
`define MSTD_OFF_REND 5'h08
`define MSTD_OFF_WEIGHT 5'h0c
`define MSTD_OFF_TRIM 5'h10
`define MSTD_OFF_SOFFS 5'h14
`define MSTD_OFF_RESULT 5'h18
`define MSTD_OFF_STATUS 5'h1c
// ==========================================================================
// config word fields
`define MSTD_CFG_MODE_LSB 0
`define MSTD_CFG_INV_BIT 3
`define MSTD_CFG_FN_LSB 4
`define MSTD_CFG_CNT_LSB 8
// ==========================================================================
// reset values and counts
`define MSTD_CFG_RST 32'h0000_0100
`define MSTD_RSTART_RST 32'h0000_0000
`define MSTD_REND_RST 32'h0000_ffff
`define MSTD_WEIGHT_RST 32'h0000_0001
`define MSTD_WIN_MAX 7'h40
`define MSTD_DIV_LAST 6'h25
`endif

/* verilog/mstd_pkg.sv */
package mstd_pkg;
  typedef enum logic [2:0] {
    MODE_I020 = 3'h0, MODE_I420 = 3'h1, MODE_V02 = 3'h2, MODE_V010 = 3'h3,
    MODE_DIGITAL = 3'h4, MODE_CNT_INF = 3'h5, MODE_CNT_DAY = 3'h6, MODE_CNT_INTRVL = 3'h7
  } chan_mode_t;
  typedef enum logic [1:0] {FN_OFF = 2'h0, FN_AVG = 2'h1, FN_MIN = 2'h2, FN_MAX = 2'h3} decay_fn_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_SCALE = 6'b000010, ST_TRIM = 6'b000100,
    ST_SCAN = 6'b001000, ST_DIV = 6'b010000, ST_OUT = 6'b100000
  } proc_state_t;
  typedef struct packed {
    logic valid;
    logic universal;
    logic [1:0] ch;
    logic [15:0] raw;
  } sample_t;
  typedef struct packed {
    logic valid;
    logic universal;
    logic [1:0] ch;
    logic signed [31:0] value;
  } result_t;
endpackage

/* verilog/measurement_scale_trim_decay.sv */
// Contract
// - scaling, trim and decay act only on samples flagged as universal input channels.
// - in current and voltage modes raw zero maps to range start and raw full scale to range end.
// - in digital mode the invert bit flips the input level before further processing.
// - in unbounded count mode each pulse adds the pulse weight to the running total.
// - in daily count mode each pulse adds the pulse weight to the running total.
// - trim and mounting offset apply only in current and voltage modes.
// - trim and mounting offset are both added to the scaled value.
// - trim is signed, so a negative trim lowers the value.
// - the decay stage combines recent values by average, minimum or maximum.
// - decay is available in all modes except unbounded and daily count.
// - the decay window holds a configurable count of at most 64 values.
// - each measurement yields exactly one combined result.
// - in digital mode a value is made on each sample and on each level change.
// - the digital level is checked for change once per second tick.
// - each measurement runs scale, then trim/offset, then decay, once.
`timescale 1ns/1ps
`include "mstd_regs.svh"
module measurement_scale_trim_decay (
  input wire logic clk, // 40 MHz
  input wire logic reset_n, // async, active low
  input wire logic ce, // freezes all state when low
  input wire mstd_pkg::sample_t smp_in, // raw sample from front end
  output logic smp_ready, // sample taken when high with valid
  input wire logic [3:0] dig_pin, // digital levels from pins
  input wire logic second_tick, // one-cycle pulse each second
  output mstd_pkg::result_t res_out, // processed value, valid pulse
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  // ========================================================================
  // register bus
  logic [31:0] cfg_ff [4], nxt_cfg [4];
  logic signed [31:0] rstart_ff [4], nxt_rstart [4];
  logic signed [31:0] rend_ff [4], nxt_rend [4];
  logic signed [31:0] weight_ff [4], nxt_weight [4];
  logic signed [31:0] trim_ff [4], nxt_trim [4];
  logic signed [31:0] soffs_ff [4], nxt_soffs [4];
  logic signed [31:0] result_ff [4], nxt_result [4];
  logic signed [31:0] total_ff [4], nxt_total [4];
  logic [6:0] fill_ff [4], nxt_fill [4];
  logic [5:0] wptr_ff [4], nxt_wptr [4];
  logic [31:0] awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wr_fire, wr_ok, cfg_wr;
  logic [1:0] wr_ch, rd_ch;
  logic [4:0] wr_off, rd_off;
  mstd_pkg::proc_state_t state_ff, nxt_state;
  logic [3:0] pend_ff, nxt_pend;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_ok = (awaddr_ff[31:7] == 25'h0000000);
  assign wr_ch = awaddr_ff[6:5];
  assign wr_off = {awaddr_ff[4:2], 2'b00};
  assign cfg_wr = wr_fire && wr_ok && (wr_off == `MSTD_OFF_CFG);
  assign rd_ch = s_axi_araddr[6:5];
  assign rd_off = {s_axi_araddr[4:2], 2'b00};

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_rstart = rstart_ff;
    nxt_rend = rend_ff;
    nxt_weight = weight_ff;
    nxt_trim = trim_ff;
    nxt_soffs = soffs_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_have = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_have = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_fire) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_ok ? 2'b00 : 2'b10;
      if (wr_ok) begin
        unique case (wr_off)
          `MSTD_OFF_CFG: nxt_cfg[wr_ch] = merge(cfg_ff[wr_ch], wdata_ff, wstrb_ff);
          `MSTD_OFF_RSTART: nxt_rstart[wr_ch] = merge(rstart_ff[wr_ch], wdata_ff, wstrb_ff);
          `MSTD_OFF_REND: nxt_rend[wr_ch] = merge(rend_ff[wr_ch], wdata_ff, wstrb_ff);
          `MSTD_OFF_WEIGHT: nxt_weight[wr_ch] = merge(weight_ff[wr_ch], wdata_ff, wstrb_ff);
          `MSTD_OFF_TRIM: nxt_trim[wr_ch] = merge(trim_ff[wr_ch], wdata_ff, wstrb_ff);
          `MSTD_OFF_SOFFS: nxt_soffs[wr_ch] = merge(soffs_ff[wr_ch], wdata_ff, wstrb_ff);
          default: ; // result and status are read only
        endcase
      end
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = 2'b00;
      unique case (rd_off)
        `MSTD_OFF_CFG: nxt_rdata = cfg_ff[rd_ch];
        `MSTD_OFF_RSTART: nxt_rdata = rstart_ff[rd_ch];
        `MSTD_OFF_REND: nxt_rdata = rend_ff[rd_ch];
        `MSTD_OFF_WEIGHT: nxt_rdata = weight_ff[rd_ch];
        `MSTD_OFF_TRIM: nxt_rdata = trim_ff[rd_ch];
        `MSTD_OFF_SOFFS: nxt_rdata = soffs_ff[rd_ch];
        `MSTD_OFF_RESULT: nxt_rdata = result_ff[rd_ch];
        default: nxt_rdata = {14'h0000, pend_ff[rd_ch], !state_ff[0], 2'b00, wptr_ff[rd_ch],
                              1'b0, fill_ff[rd_ch]};
      endcase
      if (s_axi_araddr[31:7] != 25'h0000000) begin
        nxt_rresp = 2'b10;
        nxt_rdata = 32'h0000_0000;
      end
    end
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready = !nxt_w_have && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  // ========================================================================
  // digital level sampling
  logic [3:0] sync1_ff, sync2_ff, lvl_ff, nxt_lvl, chg, dig_mode, pend_clr;

  for (genvar g = 0; g < 4; g++) begin : g_dig
    assign dig_mode[g] = (cfg_ff[g][`MSTD_CFG_MODE_LSB +: 3] == mstd_pkg::MODE_DIGITAL);
    assign chg[g] = second_tick && (sync2_ff[g] != lvl_ff[g]) && dig_mode[g];
  end

  always_comb begin
    nxt_lvl = second_tick ? sync2_ff : lvl_ff;
    nxt_pend = (pend_ff & ~pend_clr) | chg;
  end

  // ========================================================================
  // processing chain
  logic [1:0] ch_ff, nxt_ch;
  logic [15:0] raw_ff, nxt_raw;
  logic univ_ff, nxt_univ, neg_ff, nxt_neg;
  logic signed [31:0] val_ff, nxt_val, ext_ff, nxt_ext;
  logic signed [37:0] sum_ff, nxt_sum;
  logic [37:0] quo_ff, nxt_quo;
  logic [6:0] k_ff, nxt_k, used_ff, nxt_used, rem_ff, nxt_rem, ncnt, fill_up;
  logic [5:0] step_ff, nxt_step, rd_idx;
  mstd_pkg::decay_fn_t fn_ff, nxt_fn, cur_fn;
  mstd_pkg::chan_mode_t cur_mode;
  mstd_pkg::result_t out_ff, nxt_out;
  logic ready_ff, nxt_ready, is_analog, decay_ok, win_we;
  logic signed [31:0] rstart, rend, win_ff [256], entry, scaled;
  logic signed [32:0] diff;
  logic [16:0] wgt;
  logic signed [50:0] prod;
  logic signed [48:0] pprod;
  logic [7:0] rem_sh;

  assign cur_mode = mstd_pkg::chan_mode_t'(cfg_ff[ch_ff][`MSTD_CFG_MODE_LSB +: 3]);
  assign cur_fn = mstd_pkg::decay_fn_t'(cfg_ff[ch_ff][`MSTD_CFG_FN_LSB +: 2]);
  assign ncnt = (cfg_ff[ch_ff][`MSTD_CFG_CNT_LSB +: 7] == 7'h00) ? 7'h01 :
                (cfg_ff[ch_ff][`MSTD_CFG_CNT_LSB +: 7] > `MSTD_WIN_MAX) ? `MSTD_WIN_MAX :
                cfg_ff[ch_ff][`MSTD_CFG_CNT_LSB +: 7];
  assign fill_up = (fill_ff[ch_ff] == `MSTD_WIN_MAX) ? `MSTD_WIN_MAX : fill_ff[ch_ff] + 7'h01;
  assign is_analog = !cur_mode[2];
  assign decay_ok = univ_ff && (cur_fn != mstd_pkg::FN_OFF) && (cur_mode != mstd_pkg::MODE_CNT_INF)
                    && (cur_mode != mstd_pkg::MODE_CNT_DAY);
  assign rstart = rstart_ff[ch_ff];
  assign rend = rend_ff[ch_ff];
  // full scale raw counts as 65536 so the top lands exactly on range end
  assign diff = {rend[31], rend} - {rstart[31], rstart};
  assign wgt = {1'b0, raw_ff} + {16'h0000, raw_ff[15]};
  assign prod = diff * $signed({1'b0, wgt});
  assign scaled = rstart + prod[47:16];
  assign pprod = weight_ff[ch_ff] * $signed({1'b0, raw_ff});
  assign rd_idx = wptr_ff[ch_ff] - 6'h01 - k_ff[5:0];
  assign entry = win_ff[{ch_ff, rd_idx}];
  assign rem_sh = {rem_ff, quo_ff[37]};
  assign win_we = state_ff[2] && decay_ok;

  always_comb begin
    nxt_state = state_ff;
    nxt_ch = ch_ff;
    nxt_raw = raw_ff;
    nxt_univ = univ_ff;
    nxt_val = val_ff;
    nxt_ext = ext_ff;
    nxt_sum = sum_ff;
    nxt_quo = quo_ff;
    nxt_rem = rem_ff;
    nxt_neg = neg_ff;
    nxt_k = k_ff;
    nxt_used = used_ff;
    nxt_step = step_ff;
    nxt_fn = fn_ff;
    nxt_total = total_ff;
    nxt_result = result_ff;
    nxt_fill = fill_ff;
    nxt_wptr = wptr_ff;
    nxt_out = '0;
    pend_clr = 4'h0;
    unique case (state_ff)
      mstd_pkg::ST_IDLE: begin
        if (smp_in.valid && ready_ff) begin
          nxt_ch = smp_in.ch;
          nxt_raw = smp_in.raw;
          nxt_univ = smp_in.universal;
          nxt_val = {16'h0000, smp_in.raw};
          nxt_state = smp_in.universal ? mstd_pkg::ST_SCALE : mstd_pkg::ST_OUT;
        end else if (pend_ff != 4'h0) begin
          for (int c = 3; c >= 0; c--) begin
            if (pend_ff[c]) begin
              nxt_ch = 2'(c);
            end
          end
          pend_clr[nxt_ch] = 1'b1;
          nxt_raw = 16'h0000;
          nxt_univ = 1'b1;
          nxt_state = mstd_pkg::ST_SCALE;
        end
      end
      mstd_pkg::ST_SCALE: begin
        nxt_state = mstd_pkg::ST_TRIM;
        unique case (cur_mode)
          mstd_pkg::MODE_DIGITAL:
            nxt_val = {31'h00000000, lvl_ff[ch_ff] ^ cfg_ff[ch_ff][`MSTD_CFG_INV_BIT]};
          mstd_pkg::MODE_CNT_INF, mstd_pkg::MODE_CNT_DAY: begin
            nxt_total[ch_ff] = total_ff[ch_ff] + pprod[31:0];
            nxt_val = nxt_total[ch_ff];
          end
          mstd_pkg::MODE_CNT_INTRVL: nxt_val = pprod[31:0];
          default: nxt_val = scaled;
        endcase
      end
      mstd_pkg::ST_TRIM: begin
        if (is_analog) begin
          nxt_val = val_ff + trim_ff[ch_ff] + soffs_ff[ch_ff];
        end
        nxt_state = mstd_pkg::ST_OUT;
        if (decay_ok) begin
          nxt_wptr[ch_ff] = wptr_ff[ch_ff] + 6'h01;
          nxt_fill[ch_ff] = fill_up;
          nxt_used = (fill_up < ncnt) ? fill_up : ncnt;
          nxt_fn = cur_fn;
          nxt_k = 7'h00;
          nxt_sum = '0;
          nxt_state = mstd_pkg::ST_SCAN;
        end
      end
      mstd_pkg::ST_SCAN: begin
        nxt_sum = sum_ff + {{6{entry[31]}}, entry};
        if (k_ff == 7'h00 || (fn_ff == mstd_pkg::FN_MIN && entry < ext_ff) ||
            (fn_ff == mstd_pkg::FN_MAX && entry > ext_ff)) begin
          nxt_ext = entry;
        end
        nxt_k = k_ff + 7'h01;
        if (nxt_k == used_ff) begin
          if (fn_ff == mstd_pkg::FN_AVG) begin
            nxt_neg = nxt_sum[37];
            nxt_quo = nxt_sum[37] ? 38'(-nxt_sum) : nxt_sum;
            nxt_rem = 7'h00;
            nxt_step = 6'h00;
            nxt_state = mstd_pkg::ST_DIV;
          end else begin
            nxt_val = nxt_ext;
            nxt_state = mstd_pkg::ST_OUT;
          end
        end
      end
      mstd_pkg::ST_DIV: begin
        // restoring divide of the window sum by the entry count
        nxt_quo = {quo_ff[36:0], rem_sh >= {1'b0, used_ff}};
        nxt_rem = (rem_sh >= {1'b0, used_ff}) ? 7'(rem_sh - {1'b0, used_ff}) : rem_sh[6:0];
        nxt_step = step_ff + 6'h01;
        if (step_ff == `MSTD_DIV_LAST) begin
          nxt_val = neg_ff ? -nxt_quo[31:0] : nxt_quo[31:0];
          nxt_state = mstd_pkg::ST_OUT;
        end
      end
      mstd_pkg::ST_OUT: begin
        nxt_out = '{valid: 1'b1, universal: univ_ff, ch: ch_ff, value: val_ff};
        if (univ_ff) begin
          nxt_result[ch_ff] = val_ff;
        end
        nxt_state = mstd_pkg::ST_IDLE;
      end
    endcase
    if (cfg_wr) begin
      nxt_fill[wr_ch] = 7'h00;
      nxt_total[wr_ch] = 32'h0000_0000;
    end
    nxt_ready = (nxt_state == mstd_pkg::ST_IDLE);
  end

  // ========================================================================
  // state registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < 4; c++) begin
        cfg_ff[c] <= `MSTD_CFG_RST;
        rstart_ff[c] <= `MSTD_RSTART_RST;
        rend_ff[c] <= `MSTD_REND_RST;
        weight_ff[c] <= `MSTD_WEIGHT_RST;
        trim_ff[c] <= 32'h0000_0000;
        soffs_ff[c] <= 32'h0000_0000;
        result_ff[c] <= 32'h0000_0000;
        total_ff[c] <= 32'h0000_0000;
        fill_ff[c] <= 7'h00;
        wptr_ff[c] <= 6'h00;
      end
      {awaddr_ff, wdata_ff, wstrb_ff, aw_have_ff, w_have_ff} <= '0;
      {awready_ff, wready_ff, arready_ff} <= 3'b000;
      {bvalid_ff, bresp_ff, rvalid_ff, rresp_ff, rdata_ff} <= '0;
      {sync1_ff, sync2_ff, lvl_ff, pend_ff} <= 16'h0000;
      state_ff <= mstd_pkg::ST_IDLE;
      {ch_ff, raw_ff, univ_ff, neg_ff, val_ff, ext_ff, sum_ff, quo_ff} <= '0;
      {k_ff, used_ff, rem_ff, step_ff} <= '0;
      fn_ff <= mstd_pkg::FN_OFF;
      out_ff <= '0;
      ready_ff <= 1'b0;
    end else if (ce) begin
      cfg_ff <= nxt_cfg;
      rstart_ff <= nxt_rstart;
      rend_ff <= nxt_rend;
      weight_ff <= nxt_weight;
      trim_ff <= nxt_trim;
      soffs_ff <= nxt_soffs;
      result_ff <= nxt_result;
      total_ff <= nxt_total;
      fill_ff <= nxt_fill;
      wptr_ff <= nxt_wptr;
      {awaddr_ff, wdata_ff, wstrb_ff, aw_have_ff, w_have_ff} <=
        {nxt_awaddr, nxt_wdata, nxt_wstrb, nxt_aw_have, nxt_w_have};
      {awready_ff, wready_ff, arready_ff} <= {nxt_awready, nxt_wready, nxt_arready};
      {bvalid_ff, bresp_ff, rvalid_ff, rresp_ff, rdata_ff} <=
        {nxt_bvalid, nxt_bresp, nxt_rvalid, nxt_rresp, nxt_rdata};
      sync1_ff <= dig_pin;
      sync2_ff <= sync1_ff;
      lvl_ff <= nxt_lvl;
      pend_ff <= nxt_pend;
      state_ff <= nxt_state;
      {ch_ff, raw_ff, univ_ff, neg_ff, val_ff, ext_ff, sum_ff, quo_ff} <=
        {nxt_ch, nxt_raw, nxt_univ, nxt_neg, nxt_val, nxt_ext, nxt_sum, nxt_quo};
      {k_ff, used_ff, rem_ff, step_ff} <= {nxt_k, nxt_used, nxt_rem, nxt_step};
      fn_ff <= nxt_fn;
      out_ff <= nxt_out;
      ready_ff <= nxt_ready;
    end
  end

  // window storage, no reset: fill count guards stale entries
  always_ff @(posedge clk) begin
    if (ce && win_we) begin
      win_ff[{ch_ff, wptr_ff[ch_ff]}] <= nxt_val;
    end
  end

  assign smp_ready = ready_ff;
  assign res_out = out_ff;
  assign {s_axi_awready, s_axi_wready, s_axi_arready} = {awready_ff, wready_ff, arready_ff};
  assign {s_axi_bvalid, s_axi_bresp} = {bvalid_ff, bresp_ff};
  assign {s_axi_rvalid, s_axi_rresp, s_axi_rdata} = {rvalid_ff, rresp_ff, rdata_ff};

  // ========================================================================
  // assertions
  default clocking cb @(posedge clk iff ce); endclocking
  default disable iff (!reset_n);

  sequence take_s;
    state_ff[0] && smp_in.valid && ready_ff && smp_in.universal;
  endsequence
  sequence done_s;
    out_ff.valid;
  endsequence

  chain_done_a: assert property (take_s |-> ##[4:120] done_s)
    else $error("accepted sample produced no result");
  range_low_a: assert property (state_ff[1] && is_analog && raw_ff == 16'h0000
    |=> val_ff == $past(rstart)) else $error("raw zero not mapped to range start");
  range_high_a: assert property (state_ff[1] && is_analog && raw_ff == 16'hffff
    |=> val_ff == $past(rend)) else $error("full scale not mapped to range end");
  invert_level_a: assert property (state_ff[1] && cur_mode == mstd_pkg::MODE_DIGITAL
    |=> val_ff[0] == ($past(lvl_ff[ch_ff]) ^ $past(cfg_ff[ch_ff][`MSTD_CFG_INV_BIT])))
    else $error("digital level not inverted as set");
  pulse_credit_a: assert property (state_ff[1] && (cur_mode == mstd_pkg::MODE_CNT_INF ||
    cur_mode == mstd_pkg::MODE_CNT_DAY) && !cfg_wr
    |=> val_ff == $past(total_ff[ch_ff]) + $past(pprod[31:0]))
    else $error("pulse weight not credited");
  trim_skip_a: assert property (state_ff[2] && !is_analog |=> val_ff == $past(val_ff))
    else $error("trim applied outside analogue modes");
  trim_add_a: assert property (state_ff[2] && is_analog
    |=> val_ff == $past(val_ff) + $past(trim_ff[ch_ff]) + $past(soffs_ff[ch_ff]))
    else $error("trim and offset not added");
  count_nodecay_a: assert property (state_ff[1] && cur_mode == mstd_pkg::MODE_CNT_DAY
    |=> ##1 state_ff[5]) else $error("daily count entered decay");
  window_cap_a: assert property (state_ff[3] |-> used_ff <= `MSTD_WIN_MAX && used_ff != 7'h00)
    else $error("decay window out of range");
  one_result_a: assert property (done_s |=> !out_ff.valid)
    else $error("result valid longer than one cycle");
  level_event_a: assert property (chg != 4'h0 |=> (pend_ff & $past(chg)) == $past(chg))
    else $error("level change not queued");
endmodule // measurement_scale_trim_decay

/* verif/sensor_front_end.sv */
`timescale 1ns/1ps
module sensor_front_end (
  input wire logic clk, // bench clock
  input wire logic smp_ready, // design can take a sample
  output mstd_pkg::sample_t smp_in // sample towards the design
);
  initial smp_in = '0;
  // offer one sample and hold it until the design takes it
  task automatic send(input logic uni, input logic [1:0] ch, input logic [15:0] raw);
    @(posedge clk);
    smp_in <= '{valid: 1'b1, universal: uni, ch: ch, raw: raw};
    do @(posedge clk); while (!smp_ready);
    smp_in.valid <= 1'b0;
    smp_in.raw <= ~raw; // released bus no longer shows the old value
  endtask
endmodule // sensor_front_end

/* verif/measurement_scale_trim_decay_bench.sv */
`timescale 1ns/1ps
module measurement_scale_trim_decay_bench;
  logic clk, reset_n, second_tick, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, smp_ready;
  logic [3:0] dig_pin;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0] bresp, rresp, r, bq;
  mstd_pkg::sample_t smp_in;
  mstd_pkg::result_t res_out;
  int errors, n_checks, cyc;
  measurement_scale_trim_decay u_measurement_scale_trim_decay (.clk(clk), .reset_n(reset_n),
    .ce(1'b1), .smp_in(smp_in), .smp_ready(smp_ready), .dig_pin(dig_pin),
    .second_tick(second_tick), .res_out(res_out), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sensor_front_end u_sensor_front_end (.clk(clk), .smp_ready(smp_ready), .smp_in(smp_in));
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bq = bresp;
  endtask
  task automatic rd(input logic [31:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata; r = rresp;
  endtask
  task automatic wait_res(input logic uni, input logic [31:0] exp);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (!res_out.valid && n < 200);
    chk({31'h0, res_out.valid}, 32'h1);
    chk({29'h0, res_out.universal, res_out.ch}, {29'h0, uni, 2'h0});
    chk(res_out.value, exp);
  endtask
  task automatic meas(input logic uni, input logic [15:0] raw, input logic [31:0] exp);
    u_sensor_front_end.send(uni, 2'h0, raw);
    wait_res(uni, exp);
  endtask
  task automatic tick();
    // let a pin change pass both synchroniser stages first
    repeat (3) @(posedge clk);
    @(posedge clk) second_tick <= 1'b1;
    @(posedge clk) second_tick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // ==========================================================================
  // clock, reset, timeout
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  // ==========================================================================
  // scenarios
  initial begin
    reset_n = 1'b0; second_tick = 1'b0; dig_pin = 4'h0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; awaddr = '0; wdata = '0; araddr = '0;
    errors = 0; n_checks = 0; cyc = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(32'h00); chk(d, 32'h0000_0100);
    rd(32'h08); chk(d, 32'h0000_ffff);
    rd(32'h80); chk({30'h0, r}, 32'h2);
    wr(32'h80, 32'h1); chk({30'h0, bq}, 32'h2);
    rd(32'h00); chk(d, 32'h0000_0100);
    wr(32'h04, 32'd100); wr(32'h08, 32'd1100); wr(32'h10, -32'sd5); wr(32'h14, 32'd3);
    chk({30'h0, bq}, 32'h0);
    meas(1'b1, 16'h0000, 32'd98);
    meas(1'b1, 16'hffff, 32'd1098);
    meas(1'b1, 16'h8000, 32'd598);
    meas(1'b0, 16'h1234, 32'h1234);
    tick();
    wr(32'h00, 32'h10c);
    meas(1'b1, 16'h0000, 32'd1);
    @(posedge clk) dig_pin <= 4'h1;
    tick();
    wait_res(1'b1, 32'd0);
    wr(32'h00, 32'h105); wr(32'h0c, 32'd3);
    meas(1'b1, 16'h2, 32'd6);
    meas(1'b1, 16'h1, 32'd9);
    wr(32'h00, 32'h226);
    meas(1'b1, 16'h4, 32'd12);
    meas(1'b1, 16'h1, 32'd15);
    wr(32'h04, 32'd0); wr(32'h08, 32'h1_0000); wr(32'h10, 32'd0); wr(32'h14, 32'd0);
    wr(32'h00, 32'h220);
    meas(1'b1, 16'd10, 32'd10);
    meas(1'b1, 16'd5, 32'd5);
    meas(1'b1, 16'd20, 32'd5);
    meas(1'b1, 16'd30, 32'd20);
    wr(32'h00, 32'h210);
    meas(1'b1, 16'd10, 32'd10);
    meas(1'b1, 16'd30, 32'd20);
    meas(1'b1, 16'd31, 32'd30);
    rd(32'h18); chk(d, 32'd30);
    rd(32'h1c); chk(d, 32'h0000_0703);
    complete_run();
  end
endmodule // measurement_scale_trim_decay_bench
